// File: design/cfc_consts.vh
// constants for the credit flow control block
`ifndef CFC_CONSTS_VH
`define CFC_CONSTS_VH
`define CFC_CW              4
`define CFC_OFF_LIMITS      12'h000
`define CFC_OFF_PORT0       12'h004
`define CFC_OFF_PORT1       12'h008
`define CFC_OFF_UP          12'h00c
`define CFC_DN_REQ_LSB      0
`define CFC_DN_DATA_LSB     4
`define CFC_UP_DATA_LSB     8
`define CFC_TRUE_LSB        12
`define CFC_EXTRA_BIT       16
`define CFC_RST_DN_REQ      4'h4
`define CFC_RST_DN_DATA     4'h2
`define CFC_RST_UP_DATA     4'h4
`define CFC_RST_TRUE        4'h8
`define CFC_DK_READ         2'h0
`define CFC_DK_WRITE        2'h1
`define CFC_DK_CFG_RD       2'h2
`define CFC_DK_CFG_WR       2'h3
`define CFC_UK_READ         3'h0
`define CFC_UK_WRITE        3'h1
`define CFC_UK_MERGE_REQ    3'h2
`define CFC_UK_MERGE_RET    3'h3
`define CFC_UK_IO_RET       3'h4
`define CFC_UK_CFG_RET      3'h5
`define CFC_SYNC_DEPTH      3
`endif

// File: design/cfc_credit_ctr.v
// up/down credit counter with combinational next value
`default_nettype none
module cfc_credit_ctr #(
    parameter W = 4
) (
    // clock and reset
    input  wire         clk,
    input  wire         resetn,
    // count events
    input  wire         inc,
    input  wire         dec,
    // state
    output reg  [W-1:0] count,
    output reg  [W-1:0] next_count
);
    // simultaneous charge and release cancel; release of an empty count is ignored
    always @* begin
        next_count = count;
        if (inc && !(dec && count != {W{1'b0}}))
            next_count = count + {{(W-1){1'b0}}, 1'b1};
        else if (dec && !inc && count != {W{1'b0}})
            next_count = count - {{(W-1){1'b0}}, 1'b1};
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            count <= {W{1'b0}};
        else
            count <= next_count;
    end
endmodule
`default_nettype wire

// File: design/cfc_ack_phase.v
// acknowledge slot sequencer: sync slot, then request/data alternation
`default_nettype none
`include "cfc_consts.vh"
module cfc_ack_phase (
    // clock and reset
    input  wire clk,
    input  wire resetn,
    // slot of the cycle about to be driven
    output wire slot_sync,
    output wire slot_req,
    output wire slot_data,
    // slot of the synchronised incoming ack bit
    output wire rx_req,
    output wire rx_data
);
    localparam ST_SYNC = 2'h0;
    localparam ST_REQ  = 2'h1;
    localparam ST_DATA = 2'h2;

    reg [1:0]                   state;
    reg [1:0]                   next_state;
    reg [`CFC_SYNC_DEPTH-1:0]   req_lag;
    reg [`CFC_SYNC_DEPTH-1:0]   data_lag;

    assign slot_sync = (state == ST_SYNC);
    assign slot_req  = (state == ST_REQ);
    assign slot_data = (state == ST_DATA);
    // incoming bit is three edges late: output flop plus two sync stages
    assign rx_req    = req_lag[`CFC_SYNC_DEPTH-1];
    assign rx_data   = data_lag[`CFC_SYNC_DEPTH-1];

    always @* begin
        case (state)
            ST_SYNC: next_state = ST_REQ;
            ST_REQ:  next_state = ST_DATA;
            ST_DATA: next_state = ST_REQ;
            default: next_state = ST_SYNC;
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state    <= ST_SYNC;
            req_lag  <= {`CFC_SYNC_DEPTH{1'b0}};
            data_lag <= {`CFC_SYNC_DEPTH{1'b0}};
        end else begin
            state    <= next_state;
            req_lag  <= {req_lag[`CFC_SYNC_DEPTH-2:0], slot_req};
            data_lag <= {data_lag[`CFC_SYNC_DEPTH-2:0], slot_data};
        end
    end
endmodule
`default_nettype wire

// File: design/cfc_top.v
// controller-side credit flow control with apb register access
//
// Behaviour
// - one shared ack line to both port chips: queue entries and data buffers freed
// - ack line high exactly one cycle as reset releases, for phase alignment
// - then ack slots alternate request ack, data ack, forever
// - credits tracked by snooping commands, source, destination and ack lines
// - no counted request or data sent while count at limit; acks release
// - downstream request limit per port chip, programmable, reset value 4
// - a port chip request queue never fills completely with reads
// - downstream data limit per port chip, programmable, reset value 2
// - beyond the programmed data limit, extra data acks up to true limit 8
// - returned data for port requests is free; for controller requests charged
// - merge data never counted; initial merge request charged one data credit
// - downstream load-returns free; some upstream load-returns charge requests
// - upstream read: request count +1, controller request ack -1
// - upstream write: request and data +1 each, each ack -1
// - merge: both counts +1 without data; merged return is free, then data ack
// - downstream read +1; io return -1 and charges upstream request and data
// - downstream write: request and data +1; port acks release each
// - config accesses free, but one config read outstanding per port chip; code charges an upstream request and data credit for each config return
`default_nettype none
`include "cfc_consts.vh"
module cfc_top (
    // clock and reset
    input  wire        CLK_SYS,
    input  wire        RESETN,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    // downstream issue from controller logic
    input  wire        DN_ISSUE,
    input  wire        DN_PORT,
    input  wire [1:0]  DN_KIND,
    output reg  [1:0]  DN_READ_OK,
    output reg  [1:0]  DN_WRITE_OK,
    output reg  [1:0]  DN_CFG_RD_OK,
    // snooped upstream commands
    input  wire        UP_CMD,
    input  wire        UP_PORT,
    input  wire [2:0]  UP_KIND,
    // freed resources inside the controller
    input  wire        REQ_FREED,
    input  wire        DATA_FREED,
    // ack pins
    output reg         CACK,
    input  wire [1:0]  PACK
);
    reg  [31:0]           limits;
    reg  [1:0]            pack_meta;
    reg  [1:0]            pack_sync;
    reg  [1:0]            cfg_rd_busy;
    reg  [1:0]            next_cfg_rd_busy;
    reg  [`CFC_CW-1:0]    req_pend;
    reg  [`CFC_CW-1:0]    data_pend;
    reg  [`CFC_CW-1:0]    next_req_pend;
    reg  [`CFC_CW-1:0]    next_data_pend;
    reg  [31:0]           rd_mux;
    reg                   rd_hit;
    wire                  slot_sync;
    wire                  slot_req;
    wire                  slot_data;
    wire                  rx_req;
    wire                  rx_data;
    wire [`CFC_CW-1:0]    lim_dn_req  = limits[`CFC_DN_REQ_LSB+3:`CFC_DN_REQ_LSB];
    wire [`CFC_CW-1:0]    lim_dn_data = limits[`CFC_DN_DATA_LSB+3:`CFC_DN_DATA_LSB];
    wire [`CFC_CW-1:0]    lim_up_data = limits[`CFC_UP_DATA_LSB+3:`CFC_UP_DATA_LSB];
    wire [`CFC_CW-1:0]    lim_true    = limits[`CFC_TRUE_LSB+3:`CFC_TRUE_LSB];
    wire                  extra_en    = limits[`CFC_EXTRA_BIT];
    wire [`CFC_CW*2-1:0]  dn_req_cnt;
    wire [`CFC_CW*2-1:0]  dn_req_nxt;
    wire [`CFC_CW*2-1:0]  dn_data_cnt;
    wire [`CFC_CW*2-1:0]  dn_data_nxt;
    wire [`CFC_CW*2-1:0]  dn_rd_cnt;
    wire [`CFC_CW*2-1:0]  dn_rd_nxt;
    wire [`CFC_CW-1:0]    up_req_cnt;
    wire [`CFC_CW-1:0]    up_req_nxt;
    wire [`CFC_CW-1:0]    up_data_cnt;
    wire [`CFC_CW-1:0]    up_data_nxt;
    wire [1:0]            next_read_ok;
    wire [1:0]            next_write_ok;

    // upstream kinds that charge a request credit
    function up_charges_req;
        input [2:0] kind;
        begin
            up_charges_req = (kind == `CFC_UK_READ) || (kind == `CFC_UK_WRITE) ||
                             (kind == `CFC_UK_MERGE_REQ) || (kind == `CFC_UK_IO_RET) ||
                             (kind == `CFC_UK_CFG_RET);
        end
    endfunction

    // upstream kinds that charge a data credit; merged data return is free
    function up_charges_data;
        input [2:0] kind;
        begin
            up_charges_data = (kind == `CFC_UK_WRITE) || (kind == `CFC_UK_MERGE_REQ) ||
                              (kind == `CFC_UK_IO_RET) || (kind == `CFC_UK_CFG_RET);
        end
    endfunction

    // status word of one port chip
    function [31:0] port_status;
        input       busy;
        input [3:0] rd;
        input [3:0] data;
        input [3:0] req;
        begin
            port_status = {19'h00000, busy, rd, data, req};
        end
    endfunction

    wire up_req_inc  = UP_CMD && up_charges_req(UP_KIND);
    wire up_data_inc = UP_CMD && up_charges_data(UP_KIND);
    wire req_ack_tx  = slot_req && (req_pend != {`CFC_CW{1'b0}});
    wire data_ack_tx = slot_data && (data_pend != {`CFC_CW{1'b0}});
    // extra data ack once the programmed window is used but real buffers remain
    wire extra_ack   = extra_en && up_data_inc && (up_data_cnt >= lim_up_data) &&
                       (up_data_cnt < lim_true);

    cfc_ack_phase u_phase (
        .clk       (CLK_SYS),
        .resetn    (RESETN),
        .slot_sync (slot_sync),
        .slot_req  (slot_req),
        .slot_data (slot_data),
        .rx_req    (rx_req),
        .rx_data   (rx_data)
    );

    // per port downstream credits
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            wire dn_hit  = DN_ISSUE && (DN_PORT == p);
            wire up_hit  = UP_CMD && (UP_PORT == p);
            // io return from the port chip releases the downstream read request
            wire io_ret  = up_hit && (UP_KIND == `CFC_UK_IO_RET);
            wire rq_inc  = dn_hit && (DN_KIND == `CFC_DK_READ || DN_KIND == `CFC_DK_WRITE);
            wire rq_dec  = io_ret || (pack_sync[p] && rx_req);
            wire dt_inc  = dn_hit && (DN_KIND == `CFC_DK_WRITE);
            wire dt_dec  = pack_sync[p] && rx_data;
            wire rd_inc  = dn_hit && (DN_KIND == `CFC_DK_READ);
            // reads leave one queue entry free, so the queue never fills with reads
            // limitation: a forbidden issue is not blocked here, it is only counted
            assign next_read_ok[p]  = (dn_req_nxt[p*`CFC_CW +: `CFC_CW] < lim_dn_req) &&
                                      (dn_rd_nxt[p*`CFC_CW +: `CFC_CW] + 4'h1 < lim_dn_req);
            assign next_write_ok[p] = (dn_req_nxt[p*`CFC_CW +: `CFC_CW] < lim_dn_req) &&
                                      (dn_data_nxt[p*`CFC_CW +: `CFC_CW] < lim_dn_data);
            cfc_credit_ctr #(.W(`CFC_CW)) u_req (
                .clk        (CLK_SYS),
                .resetn     (RESETN),
                .inc        (rq_inc),
                .dec        (rq_dec),
                .count      (dn_req_cnt[p*`CFC_CW +: `CFC_CW]),
                .next_count (dn_req_nxt[p*`CFC_CW +: `CFC_CW])
            );
            cfc_credit_ctr #(.W(`CFC_CW)) u_data (
                .clk        (CLK_SYS),
                .resetn     (RESETN),
                .inc        (dt_inc),
                .dec        (dt_dec),
                .count      (dn_data_cnt[p*`CFC_CW +: `CFC_CW]),
                .next_count (dn_data_nxt[p*`CFC_CW +: `CFC_CW])
            );
            // reads still waiting for their return
            cfc_credit_ctr #(.W(`CFC_CW)) u_rd (
                .clk        (CLK_SYS),
                .resetn     (RESETN),
                .inc        (rd_inc),
                .dec        (io_ret),
                .count      (dn_rd_cnt[p*`CFC_CW +: `CFC_CW]),
                .next_count (dn_rd_nxt[p*`CFC_CW +: `CFC_CW])
            );
        end
    endgenerate

    cfc_credit_ctr #(.W(`CFC_CW)) u_up_req (
        .clk        (CLK_SYS),
        .resetn     (RESETN),
        .inc        (up_req_inc),
        .dec        (req_ack_tx),
        .count      (up_req_cnt),
        .next_count (up_req_nxt)
    );
    cfc_credit_ctr #(.W(`CFC_CW)) u_up_data (
        .clk        (CLK_SYS),
        .resetn     (RESETN),
        .inc        (up_data_inc),
        .dec        (data_ack_tx),
        .count      (up_data_cnt),
        .next_count (up_data_nxt)
    );

    // config read busy flag: a new read sets, its return clears, set wins
    always @* begin
        next_cfg_rd_busy = cfg_rd_busy;
        if (UP_CMD && UP_KIND == `CFC_UK_CFG_RET)
            next_cfg_rd_busy[UP_PORT] = 1'b0;
        if (DN_ISSUE && DN_KIND == `CFC_DK_CFG_RD)
            next_cfg_rd_busy[DN_PORT] = 1'b1;
    end

    // pending ack counts; a free event in the send cycle is kept
    always @* begin
        next_req_pend  = req_pend;
        next_data_pend = data_pend;
        if (REQ_FREED && !req_ack_tx)
            next_req_pend = req_pend + {{(`CFC_CW-1){1'b0}}, 1'b1};
        else if (!REQ_FREED && req_ack_tx)
            next_req_pend = req_pend - {{(`CFC_CW-1){1'b0}}, 1'b1};
        if ((DATA_FREED || extra_ack) && !data_ack_tx)
            next_data_pend = data_pend + {{(`CFC_CW-1){1'b0}}, 1'b1};
        else if (!(DATA_FREED || extra_ack) && data_ack_tx)
            next_data_pend = data_pend - {{(`CFC_CW-1){1'b0}}, 1'b1};
    end

    // register read mux
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (PADDR)
            `CFC_OFF_LIMITS: rd_mux = limits;
            `CFC_OFF_PORT0:  rd_mux = port_status(cfg_rd_busy[0], dn_rd_cnt[3:0],
                                                  dn_data_cnt[3:0], dn_req_cnt[3:0]);
            `CFC_OFF_PORT1:  rd_mux = port_status(cfg_rd_busy[1], dn_rd_cnt[7:4],
                                                  dn_data_cnt[7:4], dn_req_cnt[7:4]);
            `CFC_OFF_UP:     rd_mux = {16'h0000, data_pend, req_pend, up_data_cnt, up_req_cnt};
            default:         rd_hit = 1'b0;
        endcase
    end

    // access waits one cycle; a write lands only at the edge that shows ready
    wire                  apb_access  = PSEL && PENABLE && !PREADY;
    wire                  apb_commit  = PSEL && PENABLE && PREADY && PWRITE;

    // apb: one wait state so all outputs come from flops
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            limits  <= {15'h0000, 1'b0, `CFC_RST_TRUE, `CFC_RST_UP_DATA,
                        `CFC_RST_DN_DATA, `CFC_RST_DN_REQ};
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= apb_access;
            PSLVERR <= apb_access && !rd_hit;
            PRDATA  <= (apb_access && !PWRITE) ? rd_mux : 32'h0000_0000;
            if (apb_commit && PADDR == `CFC_OFF_LIMITS)
                limits <= {15'h0000, PWDATA[16:0]};
        end
    end

    // pin synchroniser: ack pins come from another chip, only the second stage is read
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pack_meta <= 2'h0;
            pack_sync <= 2'h0;
        end else begin
            pack_meta <= PACK;
            pack_sync <= pack_meta;
        end
    end

    // bookkeeping state behind the outputs
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            cfg_rd_busy <= 2'h0;
            req_pend    <= {`CFC_CW{1'b0}};
            data_pend   <= {`CFC_CW{1'b0}};
        end else begin
            cfg_rd_busy <= next_cfg_rd_busy;
            req_pend    <= next_req_pend;
            data_pend   <= next_data_pend;
        end
    end

    // ack line and issue permissions, all straight from flops
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            CACK         <= 1'b0;
            DN_READ_OK   <= 2'h0;
            DN_WRITE_OK  <= 2'h0;
            DN_CFG_RD_OK <= 2'h0;
        end else begin
            CACK         <= slot_sync || req_ack_tx || data_ack_tx;
            // permissions use next counts so a back-to-back issue sees its own charge
            DN_READ_OK   <= next_read_ok;
            DN_WRITE_OK  <= next_write_ok;
            DN_CFG_RD_OK <= ~next_cfg_rd_busy;
        end
    end
endmodule
`default_nettype wire

// File: verif/cfc_assertions.sv
// concurrent checks on the credit flow control top ports
`default_nettype none
`include "cfc_consts.vh"
module cfc_assertions (
    // clock, reset and apb
    input wire logic        CLK_SYS,
    input wire logic        RESETN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // issue, snoop and acks
    input wire logic        DN_ISSUE,
    input wire logic        DN_PORT,
    input wire logic [1:0]  DN_KIND,
    input wire logic [1:0]  DN_CFG_RD_OK,
    input wire logic        UP_CMD,
    input wire logic        UP_PORT,
    input wire logic [2:0]  UP_KIND,
    input wire logic        REQ_FREED,
    input wire logic        DATA_FREED,
    input wire logic        CACK
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       first;
    logic       is_sync;
    logic       slot_req;
    logic [3:0] pend_req;
    logic [3:0] pend_data;
    wire        slot_data = !first && !is_sync && !slot_req;
    // owed data acks kept as a lower bound: extra acks may use the slot too
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            first <= 1'b1;
            is_sync <= 1'b0;
            slot_req <= 1'b0;
            pend_req <= 4'h0;
            pend_data <= 4'h0;
        end else begin
            first <= 1'b0;
            is_sync <= first;
            slot_req <= !first && !slot_req;
            pend_req <= pend_req + {3'h0, REQ_FREED} - {3'h0, slot_req && CACK};
            pend_data <= pend_data + {3'h0, DATA_FREED} - {3'h0, slot_data && CACK && pend_data != 4'h0};
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    a_sync_pulse: assert property (is_sync |-> CACK) else $error("no sync pulse");
    // an ack is decided one edge before it shows, so the count of that edge is used
    a_req_ack_due: assert property (slot_req && $past(pend_req) != 4'h0 |-> CACK) else $error("req ack late");
    a_req_ack_cause: assert property (slot_req && CACK |-> $past(pend_req) != 4'h0) else $error("req ack unowed");
    a_data_ack_due: assert property (slot_data && $past(pend_data) != 4'h0 |-> CACK) else $error("data ack late");
    a_cfg_rd_busy: assert property (DN_ISSUE && DN_KIND == `CFC_DK_CFG_RD
        |=> !DN_CFG_RD_OK[$past(DN_PORT)]) else $error("cfg read not blocked");
    a_cfg_rd_hold: assert property (!first && !DN_CFG_RD_OK[0]
        && !(UP_CMD && !UP_PORT && UP_KIND == `CFC_UK_CFG_RET) |=> !DN_CFG_RD_OK[0]) else $error("cfg busy lost");
    a_apb_wait: assert property (PSEL && PENABLE && !PREADY |-> ##1 PREADY) else $error("apb answer late");
    a_ready_pulse: assert property ($rose(PREADY) |=> !PREADY) else $error("ready too long");
    a_err_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("error without ready");
    a_data_idle: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR) else $error("read data idle");
    cover property (slot_data && CACK);
    cover property (PSLVERR);
    cover property (DN_ISSUE && DN_KIND == `CFC_DK_CFG_RD);
endmodule
`default_nettype wire

// File: verif/cfc_port_model.sv
// model of the two port chips returning their ack pins
`default_nettype none
module cfc_port_model (
    // clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // controller ack and bench controls
    input wire logic       cack,
    input wire logic       stall,
    input wire logic [1:0] give_req,
    input wire logic [1:0] give_data,
    // ack pins
    output logic [1:0]     pack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       seen;
    logic       req_next;
    logic [3:0] owed_req [2];
    logic [3:0] owed_data [2];
    wire        req_slot = seen ? req_next : cack;
    wire        live = seen || cack;
    wire [1:0]  has = req_slot ? {owed_req[1] != 0, owed_req[0] != 0} : {owed_data[1] != 0, owed_data[0] != 0};
    // stall holds every owed ack back, the slow far side
    wire [1:0]  send = (live && !stall) ? has : 2'b00;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seen <= 1'b0;
            req_next <= 1'b0;
            pack <= 2'b00;
            owed_req <= '{4'h0, 4'h0};
            owed_data <= '{4'h0, 4'h0};
        end else begin
            seen <= live;
            req_next <= !req_slot;
            pack <= send;
            for (int p = 0; p < 2; p++) begin
                owed_req[p] <= owed_req[p] + {3'h0, give_req[p]} - {3'h0, send[p] && req_slot};
                owed_data[p] <= owed_data[p] + {3'h0, give_data[p]} - {3'h0, send[p] && !req_slot};
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking testbench for the credit flow control block
`default_nettype none
`include "cfc_consts.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        dn_iss = 1'b0;
    logic        dn_port = 1'b0;
    logic [1:0]  dn_kind = 2'h0;
    logic        up_cmd = 1'b0;
    logic        up_port = 1'b0;
    logic [2:0]  up_kind = 3'h0;
    logic        req_fr = 1'b0;
    logic        dat_fr = 1'b0;
    logic        stall = 1'b0;
    logic [1:0]  g_req = 2'h0;
    logic [1:0]  g_dat = 2'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  rd_ok;
    logic [1:0]  wr_ok;
    logic [1:0]  cfg_ok;
    logic        cack;
    logic [1:0]  pack;
    logic [31:0] q;
    logic        e;
    logic [7:0]  exp_up;
    int          n_fail = 0;
    int          compares = 0;
    always #2.5 clk = ~clk;
    cfc_top DUT (.CLK_SYS(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DN_ISSUE(dn_iss), .DN_PORT(dn_port),
        .DN_KIND(dn_kind), .DN_READ_OK(rd_ok), .DN_WRITE_OK(wr_ok), .DN_CFG_RD_OK(cfg_ok), .UP_CMD(up_cmd),
        .UP_PORT(up_port), .UP_KIND(up_kind), .REQ_FREED(req_fr), .DATA_FREED(dat_fr), .CACK(cack), .PACK(pack));
    cfc_port_model u_far (.clk(clk), .resetn(rstn), .cack(cack), .stall(stall), .give_req(g_req),
        .give_data(g_dat), .pack(pack));
    task summarize;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (i == 20) begin
            n_fail++;
            summarize();
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK("register read", x, q)
    endtask
    task issue(input logic p, input logic [1:0] k);
        @(posedge clk);
        dn_iss <= 1'b1;
        dn_port <= p;
        dn_kind <= k;
        @(posedge clk);
        dn_iss <= 1'b0;
    endtask
    task snoop(input logic p, input logic [2:0] k);
        @(posedge clk);
        up_cmd <= 1'b1;
        up_port <= p;
        up_kind <= k;
        @(posedge clk);
        up_cmd <= 1'b0;
    endtask
    task freed(input logic r, input logic d);
        @(posedge clk);
        req_fr <= r;
        dat_fr <= d;
        @(posedge clk);
        req_fr <= 1'b0;
        dat_fr <= 1'b0;
    endtask
    task ack(input logic [1:0] r, input logic [1:0] d);
        @(posedge clk);
        g_req <= r;
        g_dat <= d;
        @(posedge clk);
        g_req <= 2'h0;
        g_dat <= 2'h0;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        tick(1);
        `CHK("sync ack", 1'b1, cack)
        tick(1);
        `CHK("ack after sync", 1'b0, cack)
        `CHK("ok flags", 6'h3f, {rd_ok, wr_ok, cfg_ok})
        rd(`CFC_OFF_LIMITS, 32'h0000_8424);
        rd(`CFC_OFF_UP, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped error", 2'b10, {e, q[0]})
        $display("test reset done");
        repeat (2) issue(1'b0, `CFC_DK_WRITE);
        tick(1);
        `CHK("write ok at limit", 4'hb, {wr_ok, rd_ok})
        rd(`CFC_OFF_PORT0, 32'h0000_0022);
        stall <= 1'b1;
        ack(2'b01, 2'b01);
        tick(12);
        `CHK("write ok stalled", 2'b10, wr_ok)
        stall <= 1'b0;
        tick(12);
        `CHK("write ok released", 2'b11, wr_ok)
        rd(`CFC_OFF_PORT0, 32'h0000_0011);
        $display("test down write done");
        repeat (3) issue(1'b1, `CFC_DK_READ);
        tick(1);
        `CHK("read ok queue", 2'b01, rd_ok)
        rd(`CFC_OFF_PORT1, 32'h0000_0303);
        snoop(1'b1, `CFC_UK_IO_RET);
        tick(1);
        `CHK("read ok return", 2'b11, rd_ok)
        rd(`CFC_OFF_PORT1, 32'h0000_0202);
        rd(`CFC_OFF_UP, 32'h0000_0011);
        repeat (3) freed(1'b1, 1'b1);
        tick(16);
        rd(`CFC_OFF_UP, 32'h0);
        $display("test down read done");
        issue(1'b0, `CFC_DK_CFG_RD);
        tick(1);
        `CHK("cfg read busy", 2'b10, cfg_ok)
        issue(1'b0, `CFC_DK_CFG_WR);
        rd(`CFC_OFF_PORT0, 32'h0000_1011);
        snoop(1'b0, `CFC_UK_CFG_RET);
        tick(1);
        `CHK("cfg read free", 2'b11, cfg_ok)
        $display("test config done");
        exp_up = 8'h11;
        for (int k = 0; k < 6; k++) begin
            if (k >= 4) begin
                freed(1'b1, 1'b1);
                tick(6);
                exp_up = exp_up - 8'h11;
            end
            snoop(1'b1, 3'(k));
            exp_up = exp_up + {3'h0, k != 3 && k != 0, 3'h0, k != 3};
            rd(`CFC_OFF_UP, {24'h0, exp_up});
        end
        repeat (5) freed(1'b1, 1'b1);
        tick(12);
        rd(`CFC_OFF_UP, 32'h0);
        $display("test snoop table done");
        apb(1'b1, `CFC_OFF_LIMITS, 32'h0001_8114);
        rd(`CFC_OFF_LIMITS, 32'h0001_8114);
        `CHK("write ok lowered", 2'b10, wr_ok)
        ack(2'b01, 2'b01);
        tick(12);
        issue(1'b0, `CFC_DK_WRITE);
        tick(1);
        `CHK("write ok at new limit", 2'b10, wr_ok)
        repeat (2) snoop(1'b1, `CFC_UK_WRITE);
        tick(12);
        rd(`CFC_OFF_PORT0, 32'h0000_0011);
        rd(`CFC_OFF_UP, 32'h0000_0012);
        $display("test extra ack done");
        summarize();
    end
endmodule
bind cfc_top cfc_assertions u_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DN_ISSUE(DN_ISSUE), .DN_PORT(DN_PORT), .DN_KIND(DN_KIND),
    .DN_CFG_RD_OK(DN_CFG_RD_OK), .UP_CMD(UP_CMD), .UP_PORT(UP_PORT), .UP_KIND(UP_KIND), .REQ_FREED(REQ_FREED),
    .DATA_FREED(DATA_FREED), .CACK(CACK));
`default_nettype wire
